// [hdl/difl_core.sv]
`timescale 1ns/1ps
module difl_core
  import difl_pkg::*;
#(
  parameter int TBASE = TBASE_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Input terminals and their function codes
  input wire logic [NUM_IN-1:0] input_terminal_i,
  input wire logic [NUM_IN*CODE_W-1:0] in_code_i,
  // Output terminal function codes
  input wire logic [NUM_IN*CODE_W-1:0] out_code_i,
  // Parameters and drive state
  input wire logic [MODE_W-1:0] auto_run_mode_param_i,
  input wire logic [TIME_W-1:0] timer_time_param_i,
  input wire logic [MODE_W-1:0] control_mode_param_i,
  input wire logic [SRC_W-1:0] speed_source_param_i,
  input wire logic drive_stopped_i,
  // Output terminals
  output logic [NUM_IN-1:0] output_terminal_o,
  // Drive commands
  output logic [CNT_W-1:0] count_o,
  output logic overheat_alarm_o,
  output logic gate_block_o,
  output logic [MODE_W-1:0] run_mode_o,
  output logic speed_hold_o,
  output logic [2:0] dc_brake_sel_o,
  output logic sensorless_o,
  output logic run_o,
  output logic rev_o,
  output logic pwr_sel_ai2_o,
  output logic fwd_inhibit_o,
  output logic rev_inhibit_o,
  output logic panel_up_o,
  output logic panel_dn_o
);
  // ==========================================================
  // Synchronisers: second stage is read, third stage (prev_reg) only for edge detect
  logic [NUM_IN-1:0] sync1_reg;
  logic [NUM_IN-1:0] sync2_reg;
  logic [NUM_IN-1:0] prev_reg;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= input_terminal_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ==========================================================
  // Function decode: any terminal with the code asserts it
  function automatic logic any_fn(input logic [6:0] code,
                                  input logic [NUM_IN-1:0] lvl,
                                  input logic [NUM_IN*CODE_W-1:0] cv);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (lvl[i] && cv[i*CODE_W +: CODE_W] == code) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic any_asg(input logic [6:0] code,
                                   input logic [NUM_IN*CODE_W-1:0] cv);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (cv[i*CODE_W +: CODE_W] == code) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // Unlisted (reserved) codes match nothing below
  wire set1 = any_fn(FN_SET1, sync2_reg, in_code_i) |
              any_fn(FN_SETB, sync2_reg, in_code_i);
  wire clr1 = any_fn(FN_CLR1, sync2_reg, in_code_i) |
              any_fn(FN_CLRB, sync2_reg, in_code_i);
  wire set2 = any_fn(FN_SET2, sync2_reg, in_code_i) |
              any_fn(FN_SETB, sync2_reg, in_code_i);
  wire clr2 = any_fn(FN_CLR2, sync2_reg, in_code_i) |
              any_fn(FN_CLRB, sync2_reg, in_code_i);
  wire ohn_asg = any_asg(FN_OHN, in_code_i);
  wire ohn_on = any_fn(FN_OHN, sync2_reg, in_code_i);
  wire nauto = any_fn(FN_NAUTO, sync2_reg, in_code_i);
  wire tmr_in = any_fn(FN_TMRC, sync2_reg, in_code_i);
  wire hold = any_fn(FN_HOLD, sync2_reg, in_code_i);
  wire [2:0] dcb = {any_fn(FN_DCB3, sync2_reg, in_code_i),
                    any_fn(FN_DCB2, sync2_reg, in_code_i),
                    any_fn(FN_DCB1, sync2_reg, in_code_i)};
  wire sless = any_fn(FN_SLESS, sync2_reg, in_code_i);
  wire pwrsel = any_fn(FN_PWRSEL, sync2_reg, in_code_i);
  wire panel = speed_source_param_i == SRC_PANEL;
  // Only terminal two (index 1) clocks the counter
  wire cnt_edge = sync2_reg[1] & ~prev_reg[1] &
                  (in_code_i[CODE_W +: CODE_W] == FN_CNTCLK);
  // Overheat is active when any assigned terminal is off
  wire oh_trip = ohn_asg &
                 (any_fn(FN_OHN, ~sync2_reg, in_code_i) | ~ohn_on);

  // ==========================================================
  // Latches: clear has priority over set
  logic q1_reg;
  logic q2_reg;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q1_reg <= 1'b0;
      q2_reg <= 1'b0;
    end else begin
      q1_reg <= ~clr1 & (set1 | q1_reg);
      q2_reg <= ~clr2 & (set2 | q2_reg);
    end
  end

  // ==========================================================
  // Edge counter; source must keep below CNT_MAX_HZ
  logic [CNT_W-1:0] cnt_reg;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= '0;
    end else if (cnt_edge) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // Time base tick for the astable timer
  logic [23:0] tb_reg;
  wire tick = tb_reg == 24'(TBASE - 1);
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tb_reg <= '0;
    end else begin
      tb_reg <= tick ? 24'h000000 : tb_reg + 24'h000001;
    end
  end

  // ==========================================================
  // Astable timer: half period in ticks is time/2, min one
  difl_ast_t ast_reg;
  logic [TIME_W-1:0] ht_reg;
  wire [TIME_W-1:0] half = (timer_time_param_i >> 1) == '0 ?
                           TIME_W'(1) : timer_time_param_i >> 1;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ast_reg <= DIFL_AST_HOLD;
      ht_reg <= '0;
    end else begin
      case (ast_reg)
        DIFL_AST_HOLD: begin
          ht_reg <= '0;
          if (tmr_in) begin
            ast_reg <= DIFL_AST_ON;
          end
        end
        DIFL_AST_ON, DIFL_AST_OFF: begin
          if (!tmr_in) begin
            ast_reg <= DIFL_AST_HOLD;
          end else if (tick) begin
            if (ht_reg + TIME_W'(1) >= half) begin
              ht_reg <= '0;
              ast_reg <= ast_reg == DIFL_AST_ON ? DIFL_AST_OFF
                                                : DIFL_AST_ON;
            end else begin
              ht_reg <= ht_reg + TIME_W'(1);
            end
          end
        end
        default: ast_reg <= DIFL_AST_HOLD;
      endcase
    end
  end
  wire tc_out = ast_reg != DIFL_AST_OFF;
  wire tc_en = ast_reg == DIFL_AST_ON;

  // ==========================================================
  // Output terminal selection
  logic [NUM_IN-1:0] osel;
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      case (out_code_i[i*CODE_W +: CODE_W])
        OF_Q1: osel[i] = q1_reg;
        OF_Q1N: osel[i] = ~q1_reg;
        OF_Q2: osel[i] = q2_reg;
        OF_Q2N: osel[i] = ~q2_reg;
        OF_TC: osel[i] = tc_out;
        OF_TCN, OF_TCN2: osel[i] = ~tc_out;
        OF_TC_EN: osel[i] = tc_en;
        default: osel[i] = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Mode latch: normal/auto applies only while stopped
  logic [MODE_W-1:0] mode_reg;
  logic sl_reg;
  wire [MODE_W-1:0] mode_next = nauto ? AUTO_NORMAL
                                      : auto_run_mode_param_i;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg <= AUTO_NORMAL;
      sl_reg <= 1'b0;
    end else begin
      if (drive_stopped_i) begin
        mode_reg <= mode_next;
      end
      if (sless && control_mode_param_i == MODE_SLESS_ON) begin
        sl_reg <= 1'b1;
      end else if (sless && control_mode_param_i == MODE_SLESS_OFF) begin
        sl_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      output_terminal_o <= '0;
      count_o <= '0;
      overheat_alarm_o <= 1'b0;
      gate_block_o <= 1'b0;
      run_mode_o <= AUTO_NORMAL;
      speed_hold_o <= 1'b0;
      dc_brake_sel_o <= '0;
      sensorless_o <= 1'b0;
      run_o <= 1'b0;
      rev_o <= 1'b0;
      pwr_sel_ai2_o <= 1'b0;
      fwd_inhibit_o <= 1'b0;
      rev_inhibit_o <= 1'b0;
      panel_up_o <= 1'b0;
      panel_dn_o <= 1'b0;
    end else begin
      output_terminal_o <= osel;
      count_o <= cnt_reg;
      overheat_alarm_o <= oh_trip;
      gate_block_o <= oh_trip;
      run_mode_o <= mode_reg;
      speed_hold_o <= hold;
      dc_brake_sel_o <= dcb;
      sensorless_o <= sl_reg;
      run_o <= any_fn(FN_RUN, sync2_reg, in_code_i);
      rev_o <= any_fn(FN_REV, sync2_reg, in_code_i);
      pwr_sel_ai2_o <= pwrsel &
                       (control_mode_param_i == MODE_PWR);
      fwd_inhibit_o <= any_fn(FN_FINH, sync2_reg, in_code_i);
      rev_inhibit_o <= any_fn(FN_RINH, sync2_reg, in_code_i);
      panel_up_o <= panel & any_fn(FN_UP, sync2_reg, in_code_i);
      panel_dn_o <= panel & any_fn(FN_DN, sync2_reg, in_code_i);
    end
  end
endmodule // difl_core

// [hdl/difl_pkg.sv]
package difl_pkg;
  // ==========================================================
  // Terminal and code widths
  localparam int NUM_IN = 4;
  localparam int CODE_W = 7;
  localparam int CNT_W = 16;
  localparam int TIME_W = 16;
  localparam int MODE_W = 4;
  localparam int SRC_W = 5;
  // ==========================================================
  // Input function codes
  localparam logic [6:0] FN_SET1 = 7'h16;
  localparam logic [6:0] FN_CLR1 = 7'h17;
  localparam logic [6:0] FN_SET2 = 7'h18;
  localparam logic [6:0] FN_CLR2 = 7'h19;
  localparam logic [6:0] FN_SETB = 7'h1A;
  localparam logic [6:0] FN_CLRB = 7'h1B;
  localparam logic [6:0] FN_CNTCLK = 7'h1C;
  localparam logic [6:0] FN_OHN = 7'h1E;
  localparam logic [6:0] FN_NAUTO = 7'h1F;
  localparam logic [6:0] FN_TMRC = 7'h24;
  localparam logic [6:0] FN_HOLD = 7'h30;
  localparam logic [6:0] FN_DCB1 = 7'h45;
  localparam logic [6:0] FN_DCB2 = 7'h46;
  localparam logic [6:0] FN_DCB3 = 7'h47;
  localparam logic [6:0] FN_SLESS = 7'h48;
  localparam logic [6:0] FN_RUN = 7'h49;
  localparam logic [6:0] FN_REV = 7'h4A;
  localparam logic [6:0] FN_PWRSEL = 7'h4B;
  localparam logic [6:0] FN_FINH = 7'h4C;
  localparam logic [6:0] FN_RINH = 7'h4D;
  localparam logic [6:0] FN_UP = 7'h4E;
  localparam logic [6:0] FN_DN = 7'h4F;
  // ==========================================================
  // Output function codes
  localparam logic [6:0] OF_Q1 = 7'h20;
  localparam logic [6:0] OF_Q1N = 7'h21;
  localparam logic [6:0] OF_Q2 = 7'h22;
  localparam logic [6:0] OF_Q2N = 7'h23;
  localparam logic [6:0] OF_TC = 7'h2A;
  localparam logic [6:0] OF_TCN = 7'h2B;
  localparam logic [6:0] OF_TC_EN = 7'h5C;
  localparam logic [6:0] OF_TCN2 = 7'h5D;
  // ==========================================================
  // Parameter values and time base
  localparam logic [3:0] MODE_SLESS_ON = 4'h1;
  localparam logic [3:0] MODE_SLESS_OFF = 4'h3;
  localparam logic [3:0] MODE_PWR = 4'h4;
  localparam logic [4:0] SRC_PANEL = 5'h08;
  localparam logic [3:0] AUTO_NORMAL = 4'h0;
  localparam int CLK_HZ = 10_000_000;
  localparam int TBASE_MS = 100;
  localparam int TBASE_CYC = CLK_HZ / 1000 * TBASE_MS;
  localparam int CNT_MAX_HZ = 1000;
  typedef enum logic [1:0] {
    DIFL_AST_HOLD = 2'b00,
    DIFL_AST_ON = 2'b01,
    DIFL_AST_OFF = 2'b10
  } difl_ast_t;
endpackage

// [tb/difl_core_asserts.sv]
`timescale 1ns/1ps
// ==========================================================
// Port checker
module difl_core_chk
  import difl_pkg::*;
(
  // Clock, reset and stimulus
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [NUM_IN-1:0] input_terminal_i,
  input wire logic [NUM_IN*CODE_W-1:0] in_code_i,
  input wire logic [NUM_IN*CODE_W-1:0] out_code_i,
  input wire logic [MODE_W-1:0] auto_run_mode_param_i,
  input wire logic drive_stopped_i,
  // Observed outputs
  input wire logic [NUM_IN-1:0] output_terminal_o,
  input wire logic [CNT_W-1:0] count_o,
  input wire logic overheat_alarm_o,
  input wire logic gate_block_o,
  input wire logic [MODE_W-1:0] run_mode_o,
  input wire logic speed_hold_o,
  input wire logic [2:0] dc_brake_sel_o,
  input wire logic run_o,
  input wire logic rev_o
);
  logic [2*NUM_IN*CODE_W-1:0] cfg_reg;
  logic [3:0] age_reg;
  logic [3:0] hold_reg;
  logic stp_reg;
  // Ages since reset/code change and since stop/run change;
  // before they mature $past still sees stale synchroniser state
  wire [3:0] age_next = (cfg_reg != {in_code_i, out_code_i}) ? 4'h0 :
    age_reg + 4'(age_reg != 4'hF);
  wire [3:0] hold_next = (stp_reg != drive_stopped_i) ? 4'h0 :
    hold_reg + 4'(hold_reg != 4'hF);
  wire ok = age_reg == 4'hF;

  // Any terminal with code c at level v
  function automatic logic hit(input logic [6:0] c, input logic v);
    hit = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
      hit |= input_terminal_i[i] == v && in_code_i[CODE_W*i+:CODE_W] == c;
  endfunction

  // Helper registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_reg <= '0;
      age_reg <= 4'h0;
      hold_reg <= 4'h0;
      stp_reg <= 1'b0;
    end else begin
      cfg_reg <= {in_code_i, out_code_i};
      age_reg <= age_next;
      hold_reg <= hold_next;
      stp_reg <= drive_stopped_i;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  hold_follow_a:
    assert property (ok |-> speed_hold_o == $past(hit(FN_HOLD, 1'b1), 3))
    else $error("speed hold wrong");
  run_rev_a:
    assert property (ok |-> {run_o, rev_o} ==
      $past({hit(FN_RUN, 1'b1), hit(FN_REV, 1'b1)}, 3))
    else $error("run or reverse wrong");
  overheat_trip_a:
    assert property (ok |-> {overheat_alarm_o, gate_block_o} ==
      {2{$past(hit(FN_OHN, 1'b0), 3)}}) else $error("overheat wrong");
  dc_brake_src_a:
    assert property (ok |-> dc_brake_sel_o == $past({hit(FN_DCB3, 1'b1),
      hit(FN_DCB2, 1'b1), hit(FN_DCB1, 1'b1)}, 3))
    else $error("dc brake source wrong");
  count_edge_a:
    assert property (ok |-> count_o == $past(count_o) + CNT_W'(
      $past(input_terminal_i[1], 4) && !$past(input_terminal_i[1], 5) &&
      in_code_i[13:7] == FN_CNTCLK)) else $error("count step wrong");
  latch_clear_a:
    assert property (ok && out_code_i[6:0] == OF_Q1 && $past(
      hit(FN_CLR1, 1'b1) || hit(FN_CLRB, 1'b1), 4) |->
      !output_terminal_o[0]) else $error("latch not cleared");
  mode_freeze_a:
    assert property (ok && !drive_stopped_i && hold_reg > 4'h5 |->
      $stable(run_mode_o)) else $error("mode moved while running");
  mode_select_a:
    assert property (ok && drive_stopped_i && hold_reg > 4'h7 |->
      run_mode_o == ($past(hit(FN_NAUTO, 1'b1), 4) ? AUTO_NORMAL :
      $past(auto_run_mode_param_i, 4))) else $error("mode wrong");
  cover property (count_o == 16'h0002);
  cover property (overheat_alarm_o);
  cover property (ok && !drive_stopped_i && hold_reg == 4'hF);
endmodule // difl_core_chk

bind difl_core difl_core_chk u_chk (.mclk_i, .arst_n_i, .input_terminal_i,
  .in_code_i, .out_code_i, .auto_run_mode_param_i, .drive_stopped_i,
  .output_terminal_o, .count_o, .overheat_alarm_o, .gate_block_o,
  .run_mode_o, .speed_hold_o, .dc_brake_sel_o, .run_o, .rev_o);

// [tb/difl_switch_bank.sv]
`timescale 1ns/1ps
// ==========================================================
// External contact bank
module difl_switch_bank
  import difl_pkg::*;
(
  // Clock and contacts
  input wire logic mclk_i,
  input wire logic [NUM_IN-1:0] close_i,
  output logic [NUM_IN-1:0] level_o
);
  // Contacts settle one edge late; the bench paces closures
  always_ff @(posedge mclk_i) begin
    level_o <= close_i;
  end
endmodule // difl_switch_bank

// [tb/tb.sv]
`timescale 1ns/1ps
// ==========================================================
// Bench
module tb;
  import difl_pkg::*;
  localparam logic [6:0] RSV = 7'h1D; // Reserved code
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] close = 4'h0;
  logic [3:0] term;
  logic [27:0] in_code = 28'h0;
  logic [27:0] out_code = 28'h0;
  logic [3:0] auto_mode = 4'h0;
  logic [4:0] src = SRC_PANEL;
  logic stopped = 1'b1;
  logic [3:0] cmode = MODE_PWR;
  logic sl;
  logic [3:0] dout;
  logic [15:0] count;
  logic [1:0] oh;
  logic [3:0] mode;
  logic [10:0] dir;
  int num_errors = 0;
  int samples_checked = 0;
  int hi;
  logic [6:0] fl[6] = '{FN_SET1, FN_SETB, FN_CLR1, FN_CLR2, FN_SET2, FN_CLRB};
  logic [3:0] el[6] = '{4'h9, 4'h5, 4'h6, 4'hA, 4'h6, 4'hA};
  logic [6:0] fd[11] = '{FN_HOLD, FN_DCB3, FN_DCB2, FN_DCB1, FN_RUN, FN_REV,
    FN_PWRSEL, FN_FINH, FN_RINH, FN_UP, FN_DN};
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %0t got %0h exp %0h", $time, g, e); \
  end end

  always #50 mclk_i = ~mclk_i;

  difl_switch_bank u_sw (.mclk_i, .close_i(close), .level_o(term));
  difl_core #(.TBASE(4)) u_dut (.mclk_i, .arst_n_i, .input_terminal_i(term),
    .in_code_i(in_code), .out_code_i(out_code),
    .auto_run_mode_param_i(auto_mode), .timer_time_param_i(16'h0004),
    .control_mode_param_i(cmode), .speed_source_param_i(src),
    .drive_stopped_i(stopped), .output_terminal_o(dout), .count_o(count),
    .overheat_alarm_o(oh[1]), .gate_block_o(oh[0]), .run_mode_o(mode),
    .speed_hold_o(dir[10]), .dc_brake_sel_o(dir[9:7]), .run_o(dir[6]),
    .rev_o(dir[5]), .pwr_sel_ai2_o(dir[4]), .fwd_inhibit_o(dir[3]),
    .rev_inhibit_o(dir[2]), .panel_up_o(dir[1]), .panel_dn_o(dir[0]),
    .sensorless_o(sl));

  // ==========================================================
  // Access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic setc(input logic [6:0] a, b, c, d);
    in_code <= {a, b, c, d};
  endtask
  // Settles past the sync pipeline before anything is compared
  task automatic press(input logic [3:0] m);
    close <= m;
    tick(6);
  endtask
  task automatic summarize;
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog, well past the expected 40424 cycles
  initial begin
    #7_000_000;
    num_errors++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    tick(20);
    arst_n_i <= 1'b1;
    out_code <= {OF_Q2N, OF_Q2, OF_Q1N, OF_Q1};
    // Latch codes, shared by terminals one and four
    for (int i = 0; i < 6; i++) begin
      setc(fl[i], RSV, RSV, fl[i]);
      press(4'b1110);
      press(4'b0000);
      `CHK(dout, el[i])
    end
    setc(FN_CLR1, RSV, RSV, FN_SET1);
    press(4'b0001);
    press(4'b1001);
    `CHK(dout[1:0], 2'b10)
    press(4'b0000);
    // Direct functions, one at a time
    for (int i = 0; i < 11; i++) begin
      setc(RSV, fd[i], RSV, RSV);
      press(4'b0100);
      `CHK(dir, 11'h400 >> i)
      press(4'b0000);
    end
    src <= 5'h00;
    setc(RSV, FN_UP, RSV, RSV);
    press(4'b0100);
    `CHK(dir, 11'h000)
    setc(RSV, RSV, RSV, FN_OHN);
    press(4'b0001);
    `CHK(oh, 2'b00)
    press(4'b0000);
    `CHK(oh, 2'b11)
    press(4'b0001);
    `CHK(oh, 2'b00)
    setc(RSV, RSV, RSV, FN_NAUTO);
    auto_mode <= 4'h2;
    press(4'b0000);
    `CHK(mode, 4'h2)
    press(4'b0001);
    `CHK(mode, 4'h0)
    stopped <= 1'b0;
    press(4'b0000);
    `CHK(mode, 4'h0)
    stopped <= 1'b1;
    tick(6);
    `CHK(mode, 4'h2)
    // Counter clock; only terminal two may count
    setc(RSV, FN_CNTCLK, FN_CNTCLK, FN_CNTCLK);
    for (int i = 0; i < 2; i++) begin
      press(4'b0111);
      tick(10000);
      press(4'b0000);
      tick(10000);
    end
    `CHK(count, 16'h0002)
    // Sensorless change follows the control mode; power select needs mode 4
    setc(RSV, RSV, FN_PWRSEL, FN_SLESS);
    cmode <= MODE_SLESS_ON;
    press(4'b0011);
    `CHK(sl, 1'b1)
    `CHK(dir[4], 1'b0)
    cmode <= MODE_SLESS_OFF;
    press(4'b0011);
    `CHK(sl, 1'b0)
    press(4'b0000);
    out_code <= {OF_Q1, OF_TCN, OF_TC_EN, OF_TC};
    setc(FN_TMRC, RSV, RSV, RSV);
    press(4'b0000);
    `CHK(dout[2:0], 3'b001)
    press(4'b1000);
    // Skip the first half period, whose length depends on the tick phase
    tick(16);
    hi = 0;
    repeat (64) @(negedge mclk_i) hi += int'(dout[0] === 1'b1);
    `CHK(hi, 32)
    summarize();
  end
endmodule // tb
